// ---- design/grl_core.sv ----
// Bus remote/local, talker/listener, lockout, clear, trigger and poll logic.
// Assumes a front end that decodes interface messages into one-cycle commands.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module grl_core
    import grl_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_ren,
    input  wire logic       i_ifc,
    input  wire grl_cmd_t   i_cmd,
    input  wire logic       i_acq_req,
    input  wire logic       i_key_local,
    input  wire logic       i_key_trig,
    input  wire logic       i_key_out_off,
    input  wire logic [7:0] i_keys,
    input  wire logic       i_msg_shown,
    input  wire logic [7:0] i_cond,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic [7:0]      o_rdata,
    output grl_ind_t        o_ind,
    output logic            o_lockout,
    output logic            o_acq_accept,
    output logic            o_acq_reject,
    output logic            o_dev_clear,
    output logic            o_trigger,
    output logic            o_trig_key,
    output logic            o_out_off,
    output logic [7:0]      o_keys,
    output logic            o_display_normal,
    output logic [7:0]      o_status_byte,
    output logic            o_status_valid
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        grl_rl_t    rl;
        logic       talk;
        logic       listen;
        logic       spoll;
        logic       srq;
        logic [7:0] cond_seen;
        logic [4:0] my_addr;
        logic [1:0] tsrc;
        logic [7:0] enable;
        logic [7:0] rdata;
        logic       acq_accept;
        logic       acq_reject;
        logic       dev_clear;
        logic       trigger;
        logic       trig_key;
        logic       out_off;
        logic [7:0] keys;
        logic       display_normal;
        logic [7:0] status_byte;
        logic       status_valid;
        logic       remote_ind;
        logic       lock_ind;
        grl_cmd_t   cmd_d;
    } grl_st_t;
    grl_st_t st_r;
    grl_st_t st_nxt;

    logic mine;
    logic ifc_clear;
    logic is_remote;
    logic is_lock;
    logic [7:0] hit;

    // The address match is registered, so the command is delayed to line up.
    grl_cmd_t cmd_d_r;

    grl_addr_match u_match (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_cmd     (i_cmd),
        .i_my_addr (st_r.my_addr),
        .o_mine    (mine)
    );

    grl_ifc_filter u_ifc (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_ifc   (i_ifc),
        .o_clear (ifc_clear)
    );

    assign cmd_d_r = st_r.cmd_d;

    assign is_remote = (st_r.rl == GRL_REMOTE) || (st_r.rl == GRL_RWLS);
    assign is_lock   = (st_r.rl == GRL_LWLS) || (st_r.rl == GRL_RWLS);
    assign hit       = i_cond & st_r.enable;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt            = st_r;
        st_nxt.dev_clear  = 1'b0;
        st_nxt.trigger    = 1'b0;
        st_nxt.acq_accept = 1'b0;
        st_nxt.acq_reject = 1'b0;
        st_nxt.rdata      = 8'h00;
        st_nxt.cmd_d      = i_cmd;

        if (cmd_d_r.valid) begin
            case (cmd_d_r.code)
                CMD_MLA: begin
                    if (mine) begin
                        st_nxt.listen = 1'b1;
                        st_nxt.talk = 1'b0;
                        if (i_ren && !is_remote) begin
                            st_nxt.rl = is_lock ? GRL_RWLS : GRL_REMOTE;
                        end
                    end
                end
                CMD_MTA: begin
                    if (mine) begin
                        st_nxt.talk = 1'b1;
                        st_nxt.listen = 1'b0;
                    end
                end
                CMD_UNT: st_nxt.talk = 1'b0;
                CMD_UNL: st_nxt.listen = 1'b0;
                CMD_LLO: st_nxt.rl = is_remote ? GRL_RWLS : GRL_LWLS;
                CMD_GTL: begin
                    if (st_r.listen) begin
                        st_nxt.rl = GRL_LOCAL;
                    end
                end
                CMD_DCL: st_nxt.dev_clear = 1'b1;
                CMD_SDC: st_nxt.dev_clear = st_r.listen;
                CMD_GET: begin
                    st_nxt.trigger = st_r.listen && (st_r.tsrc == TRIG_BUS);
                end
                CMD_SPE: st_nxt.spoll = 1'b1;
                CMD_SPD: st_nxt.spoll = 1'b0;
                default: st_nxt.spoll = st_r.spoll;
            endcase
        end

        // Local key works only in plain remote, never under lockout.
        if (i_key_local && (st_r.rl == GRL_REMOTE)) begin
            st_nxt.rl             = GRL_LOCAL;
            st_nxt.display_normal = 1'b1;
        end else if (!i_msg_shown) begin
            st_nxt.display_normal = 1'b0;
        end

        // Remote enable false returns everything to local, lockout included.
        if (!i_ren) begin
            st_nxt.rl = GRL_LOCAL;
        end

        // Clear touches only interface state; settings and data are elsewhere.
        if (ifc_clear) begin
            st_nxt.rl    = is_lock ? GRL_LWLS : GRL_LOCAL;
            st_nxt.talk  = 1'b0;
            st_nxt.listen = 1'b0;
            st_nxt.spoll = 1'b0;
        end

        if (i_acq_req) begin
            st_nxt.acq_accept = is_remote;
            st_nxt.acq_reject = !is_remote;
        end

        // Service request: a new enabled condition wins over the poll clear.
        if (st_r.spoll && st_r.talk && st_r.srq) begin
            st_nxt.srq = 1'b0;
        end
        if (hit == 8'h00) begin
            st_nxt.srq = 1'b0;
        end
        if ((hit & ~st_r.cond_seen) != 8'h00) begin
            st_nxt.srq = 1'b1;
        end
        st_nxt.cond_seen = hit;

        st_nxt.status_byte  = {st_r.srq, st_r.cond_seen[6:0]};
        st_nxt.status_valid = st_r.spoll && st_r.talk;

        // Front panel gating.
        // Lockout silences every key but output off, even while in local.
        st_nxt.keys     = (is_remote || is_lock) ? 8'h00 : i_keys;
        st_nxt.trig_key = i_key_trig && !is_lock
                          && (!is_remote || st_r.tsrc == TRIG_MAN);
        st_nxt.out_off  = i_key_out_off;

        if (i_wr) begin
            case (i_addr)
                REG_CTRL: begin
                    if (i_wdata[4:0] <= ADDR_MAX) begin
                        st_nxt.my_addr = i_wdata[4:0];
                    end
                    st_nxt.tsrc = i_wdata[CTRL_TSRC_LSB +: 2];
                end
                REG_ENABLE: st_nxt.enable = i_wdata;
                default:    st_nxt.enable = st_nxt.enable;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                REG_CTRL:   st_nxt.rdata = {1'b0, st_r.tsrc, st_r.my_addr};
                REG_ENABLE: st_nxt.rdata = st_r.enable;
                REG_COND:   st_nxt.rdata = st_r.cond_seen;
                REG_STATE:  st_nxt.rdata = {2'b00, st_r.spoll, st_r.srq,
                                            st_r.listen, st_r.talk, st_r.rl};
                default:    st_nxt.rdata = 8'h00;
            endcase
        end

        // Indicators are registered copies of the next state, so they move with it.
        st_nxt.remote_ind = (st_nxt.rl == GRL_REMOTE) || (st_nxt.rl == GRL_RWLS);
        st_nxt.lock_ind   = (st_nxt.rl == GRL_LWLS) || (st_nxt.rl == GRL_RWLS);
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r         <= '0;
            st_r.my_addr <= ADDR_DEFAULT;
            st_r.tsrc    <= TRIG_IMM;
            st_r.enable  <= ENABLE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata          = st_r.rdata;
    assign o_ind.remote_state_indicator    = st_r.remote_ind;
    assign o_ind.talk                      = st_r.talk;
    assign o_ind.listener_active_indicator = st_r.listen;
    assign o_ind.srq                       = st_r.srq;
    assign o_lockout                       = st_r.lock_ind;
    assign o_acq_accept     = st_r.acq_accept;
    assign o_acq_reject     = st_r.acq_reject;
    assign o_dev_clear      = st_r.dev_clear;
    assign o_trigger        = st_r.trigger;
    assign o_trig_key       = st_r.trig_key;
    assign o_out_off        = st_r.out_off;
    assign o_keys           = st_r.keys;
    assign o_display_normal = st_r.display_normal;
    assign o_status_byte    = st_r.status_byte;
    assign o_status_valid   = st_r.status_valid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_ifc_idle;
        @(posedge i_clock) disable iff (!i_rst_n)
        ifc_clear |=> (!o_ind.talk && !o_ind.listener_active_indicator
                       && !o_ind.remote_state_indicator);
    endproperty
    a_ifc_idle: assert property (p_ifc_idle) else $error("clear left bus active");

    property p_ren_alone;
        @(posedge i_clock) disable iff (!i_rst_n)
        (!is_remote && !(cmd_d_r.valid && cmd_d_r.code == CMD_MLA)) |=> !is_remote;
    endproperty
    a_ren_alone: assert property (p_ren_alone) else $error("remote without listen");

    property p_acq;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_acq_req |=> (o_acq_accept == $past(is_remote)) && (o_acq_reject != o_acq_accept);
    endproperty
    a_acq: assert property (p_acq) else $error("acquisition gate wrong");

    property p_keys;
        @(posedge i_clock) disable iff (!i_rst_n)
        is_remote |=> (o_keys == 8'h00);
    endproperty
    a_keys: assert property (p_keys) else $error("keys live in remote");

    property p_out_off;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_key_out_off |=> o_out_off;
    endproperty
    a_out_off: assert property (p_out_off) else $error("output off blocked");

    property p_lock_local;
        @(posedge i_clock) disable iff (!i_rst_n)
        (is_lock && i_ren && !ifc_clear && !(cmd_d_r.valid && cmd_d_r.code == CMD_GTL))
            |=> is_lock;
    endproperty
    a_lock_local: assert property (p_lock_local) else $error("lockout lost");

    property p_dcl;
        @(posedge i_clock) disable iff (!i_rst_n)
        (cmd_d_r.valid && cmd_d_r.code == CMD_DCL) |=> o_dev_clear;
    endproperty
    a_dcl: assert property (p_dcl) else $error("device clear missed");

    property p_get;
        @(posedge i_clock) disable iff (!i_rst_n)
        o_trigger |-> $past(st_r.tsrc) == TRIG_BUS;
    endproperty
    a_get: assert property (p_get) else $error("trigger from wrong source");

    property p_srq_new;
        @(posedge i_clock) disable iff (!i_rst_n)
        ((hit & ~st_r.cond_seen) != 8'h00) |=> o_ind.srq;
    endproperty
    a_srq_new: assert property (p_srq_new) else $error("request not raised");

    property p_lock_keys;
        @(posedge i_clock) disable iff (!i_rst_n)
        is_lock |=> (o_keys == 8'h00) && !o_trig_key;
    endproperty
    a_lock_keys: assert property (p_lock_keys) else $error("keys live under lockout");

    property p_local_key;
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_key_local && (st_r.rl == GRL_REMOTE)) |=> !o_ind.remote_state_indicator;
    endproperty
    a_local_key: assert property (p_local_key) else $error("local key ignored");

    property p_one_role;
        @(posedge i_clock) disable iff (!i_rst_n)
        !(o_ind.talk && o_ind.listener_active_indicator);
    endproperty
    a_one_role: assert property (p_one_role) else $error("talker and listener at once");
endmodule

// ---- design/grl_pkg.sv ----
// Package for the bus remote/local state logic: command codes, addresses, timing.
// Assumes a decoded interface-message stream from a bus front end.
package grl_pkg;

    // ----------------------------------------------------------------
    // Bus command codes as delivered by the front end decoder
    // ----------------------------------------------------------------
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_LLO  = 4'h1;
    localparam logic [3:0] CMD_GTL  = 4'h2;
    localparam logic [3:0] CMD_DCL  = 4'h3;
    localparam logic [3:0] CMD_SDC  = 4'h4;
    localparam logic [3:0] CMD_GET  = 4'h5;
    localparam logic [3:0] CMD_MTA  = 4'h6;
    localparam logic [3:0] CMD_MLA  = 4'h7;
    localparam logic [3:0] CMD_UNT  = 4'h8;
    localparam logic [3:0] CMD_UNL  = 4'h9;
    localparam logic [3:0] CMD_SPE  = 4'hA;
    localparam logic [3:0] CMD_SPD  = 4'hB;

    // ----------------------------------------------------------------
    // Addresses, trigger sources and register map
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_MAX     = 5'h1E;
    localparam logic [4:0] ADDR_DEFAULT = 5'h10;
    localparam logic [1:0] TRIG_IMM     = 2'h0;
    localparam logic [1:0] TRIG_BUS     = 2'h1;
    localparam logic [1:0] TRIG_MAN     = 2'h2;
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_ENABLE   = 4'h1;
    localparam logic [3:0] REG_COND     = 4'h2;
    localparam logic [3:0] REG_STATE    = 4'h3;
    localparam int CTRL_ADDR_LSB = 0;
    localparam int CTRL_TSRC_LSB = 5;
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ     = 50;
    localparam int IFC_MIN_US  = 100;
    localparam int IFC_MIN_CYC = IFC_MIN_US * CLK_MHZ;

    typedef enum logic [1:0] {
        GRL_LOCAL  = 2'b00,
        GRL_REMOTE = 2'b01,
        GRL_LWLS   = 2'b10,
        GRL_RWLS   = 2'b11
    } grl_rl_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] code;
        logic [4:0] addr;
    } grl_cmd_t;

    typedef struct packed {
        logic remote_state_indicator;
        logic talk;
        logic listener_active_indicator;
        logic srq;
    } grl_ind_t;

endpackage

// ---- design/grl_addr_match.sv ----
// Address comparator for talk and listen addresses.
// Assumes the command stream is synchronous to i_clock.
`timescale 1ns/1ns
module grl_addr_match
    import grl_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire grl_cmd_t   i_cmd,
    input  wire logic [4:0] i_my_addr,
    output logic            o_mine
);
    // ----------------------------------------------------------------
    // Registered match
    // ----------------------------------------------------------------
    typedef struct packed {
        logic mine;
    } grl_am_st_t;
    grl_am_st_t st_r;
    grl_am_st_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.mine = i_cmd.valid && (i_cmd.addr == i_my_addr);
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_mine = st_r.mine;
endmodule

// ---- design/grl_ifc_filter.sv ----
// Interface-clear qualifier: the line must stand for the minimum time.
// Assumes the bus line is already synchronous to i_clock.
`timescale 1ns/1ns
module grl_ifc_filter
    import grl_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_ifc,
    output logic      o_clear
);
    // ----------------------------------------------------------------
    // Hold counter
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [12:0] cnt;
        logic        clear;
    } grl_if_st_t;
    grl_if_st_t st_r;
    grl_if_st_t st_nxt;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.clear = 1'b0;
        if (!i_ifc) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt != 13'(IFC_MIN_CYC - 1)) begin
            st_nxt.cnt = st_r.cnt + 13'h0001;
            // One pulse once the line has stood long enough.
            st_nxt.clear = (st_r.cnt == 13'(IFC_MIN_CYC - 2));
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_clear = st_r.clear;
endmodule

// ---- test/grl_ctl_model.sv ----
// Bus controller model: drives remote enable, interface clear and commands.
// Assumes the device samples its inputs on the rising edge of i_clock.
`timescale 1ns/1ns
module grl_ctl_model
    import grl_pkg::*;
(
    input  wire logic i_clock,
    output grl_cmd_t  o_cmd,
    output logic      o_ren,
    output logic      o_ifc
);
    initial begin
        o_cmd = '0;
        o_ren = 1'b0;
        o_ifc = 1'b0;
    end

    // ----------------------------------------------------------------
    // Controller actions
    // ----------------------------------------------------------------
    // Idle cycles carry the inverted last code, so a device that ignores valid is caught.
    task automatic send(input logic [3:0] code, input logic [4:0] addr);
        @(posedge i_clock);
        o_cmd <= '{valid: 1'b1, code: code, addr: addr};
        @(posedge i_clock);
        o_cmd <= '{valid: 1'b0, code: ~code, addr: ~addr};
    endtask

    task automatic set_ren(input logic lvl);
        @(posedge i_clock);
        o_ren <= lvl;
    endtask

    // A short hold is used only where a scenario means to break the minimum.
    task automatic pulse_ifc(input int cycles);
        @(posedge i_clock);
        o_ifc <= 1'b1;
        repeat (cycles) @(posedge i_clock);
        o_ifc <= 1'b0;
    endtask
endmodule

// ---- test/tb_gpib_remote_local_state_logic.sv ----
// Self-checking bench for the remote/local state core.
// Assumes grl_core with its filter and address comparator, and the controller model.
`timescale 1ns/1ns
module tb_gpib_remote_local_state_logic;
    import grl_pkg::*;

    logic       i_clock;
    logic       i_rst_n;
    logic       i_acq_req;
    logic       i_key_local;
    logic       i_key_trig;
    logic       i_key_out_off;
    logic       i_msg_shown;
    logic       i_wr;
    logic       i_rd;
    logic [7:0] i_keys;
    logic [7:0] i_cond;
    logic [7:0] i_wdata;
    logic [3:0] i_addr;
    grl_cmd_t   cmd;
    logic       ren;
    logic       ifc;
    logic [7:0] o_rdata;
    logic [7:0] o_keys;
    logic [7:0] o_status_byte;
    grl_ind_t   o_ind;
    logic       o_lockout;
    logic       o_acq_accept;
    logic       o_acq_reject;
    logic       o_dev_clear;
    logic       o_trigger;
    logic       o_trig_key;
    logic       o_out_off;
    logic       o_display_normal;
    logic       o_status_valid;
    int         miscompares;
    int         samples_checked;
    int         dc_cnt;
    int         trg_cnt;

    grl_ctl_model ctl (.i_clock(i_clock), .o_cmd(cmd), .o_ren(ren), .o_ifc(ifc));

    grl_core DUT (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_ren(ren), .i_ifc(ifc), .i_cmd(cmd),
        .i_acq_req(i_acq_req), .i_key_local(i_key_local), .i_key_trig(i_key_trig),
        .i_key_out_off(i_key_out_off), .i_keys(i_keys), .i_msg_shown(i_msg_shown),
        .i_cond(i_cond), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_ind(o_ind), .o_lockout(o_lockout),
        .o_acq_accept(o_acq_accept), .o_acq_reject(o_acq_reject),
        .o_dev_clear(o_dev_clear), .o_trigger(o_trigger), .o_trig_key(o_trig_key),
        .o_out_off(o_out_off), .o_keys(o_keys), .o_display_normal(o_display_normal),
        .o_status_byte(o_status_byte), .o_status_valid(o_status_valid)
    );

    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end

    // Pulses are counted rather than caught at one edge, so latency slack is harmless.
    always @(posedge i_clock) begin
        if (o_dev_clear === 1'b1) dc_cnt++;
        if (o_trigger === 1'b1) trg_cnt++;
    end

    // ----------------------------------------------------------------
    // Checks and access tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        chk(got[7:0], exp[7:0]);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask

    task automatic cmd_to(input logic [3:0] c, input logic [4:0] a);
        ctl.send(c, a);
        step(3);
    endtask

    task automatic acq(input logic [7:0] exp);
        @(posedge i_clock);
        i_acq_req <= 1'b1;
        @(posedge i_clock);
        i_acq_req <= 1'b0;
        #1;
        chk({6'h00, o_acq_accept, o_acq_reject}, exp);
    endtask

    task automatic press_local;
        @(posedge i_clock);
        i_key_local <= 1'b1;
        @(posedge i_clock);
        i_key_local <= 1'b0;
        step(3);
    endtask

    task automatic wait_srq(input logic lvl);
        int n;
        n = 0;
        while (o_ind.srq !== lvl && n < 50) begin
            @(posedge i_clock);
            n++;
        end
        #1;
        if (n == 50) begin
            miscompares++;
            print_verdict();
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge i_clock);
        miscompares++;
        print_verdict();
    end

    initial begin
        {i_rst_n, i_acq_req, i_key_local, i_key_trig, i_key_out_off, i_msg_shown} = '0;
        {i_wr, i_rd, i_keys, i_cond, i_wdata, i_addr} = '0;
        {miscompares, samples_checked, dc_cnt, trg_cnt} = '0;
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        step(2);
        chk({4'h0, o_ind}, 8'h00);
        chk({7'h00, o_lockout}, 8'h00);
        rd(REG_CTRL, 8'h10);
        rd(REG_STATE, 8'h00);
        rd(4'hF, 8'h00);
        ctl.set_ren(1'b1);
        step(4);
        chk({4'h0, o_ind}, 8'h00);
        cmd_to(CMD_MLA, 5'h03);
        chk({4'h0, o_ind}, 8'h00);
        acq(8'h01);
        cmd_to(CMD_MLA, ADDR_DEFAULT);
        chk({4'h0, o_ind}, 8'h0A);
        acq(8'h02);
        @(posedge i_clock);
        i_keys     <= 8'hFF;
        i_key_trig <= 1'b1;
        step(3);
        chk(o_keys, 8'h00);
        chk({7'h00, o_trig_key}, 8'h00);
        wr(REG_CTRL, 8'h50);
        step(3);
        chk({7'h00, o_trig_key}, 8'h01);
        @(posedge i_clock);
        i_msg_shown <= 1'b1;
        press_local();
        chk({4'h0, o_ind}, 8'h02);
        chk({7'h00, o_display_normal}, 8'h01);
        chk(o_keys, 8'hFF);
        cmd_to(CMD_MTA, ADDR_DEFAULT);
        chk({4'h0, o_ind}, 8'h04);
        cmd_to(CMD_MLA, ADDR_DEFAULT);
        chk({4'h0, o_ind}, 8'h0A);
        cmd_to(CMD_UNL, 5'h00);
        chk({4'h0, o_ind}, 8'h08);
        cmd_to(CMD_MTA, ADDR_DEFAULT);
        cmd_to(CMD_UNT, 5'h00);
        chk({4'h0, o_ind}, 8'h08);
        cmd_to(CMD_LLO, 5'h00);
        chk({7'h00, o_lockout}, 8'h01);
        @(posedge i_clock);
        i_key_out_off <= 1'b1;
        press_local();
        chk({4'h0, o_ind}, 8'h08);
        chk({7'h00, o_out_off}, 8'h01);
        chk(o_keys, 8'h00);
        chk({7'h00, o_trig_key}, 8'h00);
        cmd_to(CMD_MLA, ADDR_DEFAULT);
        cmd_to(CMD_GTL, 5'h00);
        chk({4'h0, o_ind}, 8'h02);
        chk({7'h00, o_lockout}, 8'h00);
        chk(o_keys, 8'hFF);
        cmd_to(CMD_UNL, 5'h00);
        cmd_to(CMD_DCL, 5'h00);
        chk_cnt(dc_cnt, 1);
        cmd_to(CMD_SDC, 5'h00);
        chk_cnt(dc_cnt, 1);
        cmd_to(CMD_MLA, ADDR_DEFAULT);
        cmd_to(CMD_SDC, 5'h00);
        chk_cnt(dc_cnt, 2);
        cmd_to(CMD_GET, 5'h00);
        chk_cnt(trg_cnt, 0);
        wr(REG_CTRL, 8'h3E);
        cmd_to(CMD_GET, 5'h00);
        chk_cnt(trg_cnt, 1);
        wr(REG_CTRL, 8'h3F);
        rd(REG_CTRL, 8'h3E);
        cmd_to(CMD_UNL, 5'h00);
        cmd_to(CMD_MLA, ADDR_DEFAULT);
        chk({4'h0, o_ind}, 8'h08);
        cmd_to(CMD_MLA, 5'h1E);
        chk({4'h0, o_ind}, 8'h0A);
        wr(REG_ENABLE, 8'h01);
        @(posedge i_clock);
        i_cond <= 8'h01;
        wait_srq(1'b1);
        chk({4'h0, o_ind}, 8'h0B);
        @(posedge i_clock);
        i_cond <= 8'h00;
        wait_srq(1'b0);
        chk({4'h0, o_ind}, 8'h0A);
        @(posedge i_clock);
        i_cond <= 8'h01;
        wait_srq(1'b1);
        cmd_to(CMD_SPE, 5'h00);
        cmd_to(CMD_MTA, 5'h1E);
        chk({7'h00, o_status_valid}, 8'h01);
        chk(o_status_byte & 8'h7F, 8'h01);
        cmd_to(CMD_SPD, 5'h00);
        step(2);
        chk({4'h0, o_ind}, 8'h0C);
        ctl.pulse_ifc(100);
        step(4);
        chk({4'h0, o_ind}, 8'h0C);
        ctl.pulse_ifc(IFC_MIN_CYC + 4);
        step(4);
        chk({4'h0, o_ind}, 8'h00);
        rd(REG_CTRL, 8'h3E);
        rd(REG_ENABLE, 8'h01);
        cmd_to(CMD_MLA, 5'h1E);
        cmd_to(CMD_LLO, 5'h00);
        chk({7'h00, o_lockout}, 8'h01);
        @(posedge i_clock);
        i_rst_n <= 1'b0;
        step(2);
        @(posedge i_clock);
        i_rst_n <= 1'b1;
        step(2);
        chk({7'h00, o_lockout}, 8'h00);
        chk({4'h0, o_ind}, 8'h00);
        rd(REG_CTRL, 8'h10);
        print_verdict();
    end
endmodule
